// ===== rtl/byte_cpu_timing.sv
// Instruction length and execution timing sequencer for a pipelined
// byte-wide CPU core, plus the far-data move path to on-chip memory.
// Assumes the fetch unit presents one opcode at a time with its branch
// outcome, and that flash and data memory answer a read one cycle later.
`timescale 1ns/10ps
module byte_cpu_timing
    import byte_cpu_timing_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic op_valid,
    input wire logic [7:0] op_code,
    input wire logic branch_taken,
    input wire logic far_flash_sel,
    input wire logic [ADDR_W-1:0] far_addr,
    input wire logic [7:0] far_wdata,
    input wire logic [7:0] far_rdata,
    output logic busy_ff,
    output logic last_ff,
    output logic done_ff,
    output logic [1:0] bytes_ff,
    output logic [3:0] cycles_ff,
    output op_group_t group_ff,
    output flag_mask_t flags_ff,
    output logic flash_req_ff,
    output logic xram_req_ff,
    output logic mem_we_ff,
    output logic [ADDR_W-1:0] mem_addr_ff,
    output logic [7:0] mem_wdata_ff,
    output logic rd_valid_ff,
    output logic [7:0] rd_data_ff
);

    // Builds one decode record; keeps the case table short
    function automatic op_info_t mk(input logic [1:0] b,
                                    input logic [3:0] c,
                                    input op_group_t g);
        op_info_t r;
        r = '0;
        r.bytes = b;
        r.cycles = c;
        r.grp = g;
        return r;
    endfunction

    // Full opcode decode: length, taken-path cycles, group, flag effects
    function automatic op_info_t decode(input logic [7:0] op);
        op_info_t d;
        logic [3:0] row;
        logic [3:0] col;
        op_group_t g;
        row = op[7:4];
        col = op[3:0];
        // Unlisted opcodes fall back to one byte, one clock, no flags
        d = mk(2'd1, 4'd1, grp_other);
        // Row group for the regular accumulator columns
        case (row)
            `ROW_ADD, `ROW_ADD_CY, `ROW_SUB_BW: g = grp_arith;
            `ROW_OR, `ROW_AND, `ROW_XOR: g = grp_logic;
            `ROW_INC, `ROW_DEC: g = grp_arith;
            `ROW_COPY_A: g = grp_copy;
            default: g = grp_other;
        endcase
        if (g != grp_other) begin
            if (col >= `COL_BANK) begin
                // Bank register forms: one byte, one clock
                d = mk(2'd1, 4'd1, g);
            end else if (col == `COL_IND_LO || col == `COL_IND_HI) begin
                // Pointer-indirect forms spend one clock on the RAM read
                d = mk(2'd1, 4'd2, g);
            end else if (col == `COL_DIR) begin
                // Direct address arrives as the second program byte
                d = mk(2'd2, 4'd2, g);
            end else if (col == `COL_IMM) begin
                // Increment and decrement of A sit in this column
                if (row == `ROW_INC || row == `ROW_DEC) begin
                    d = mk(2'd1, 4'd1, g);
                end else begin
                    d = mk(2'd2, 4'd2, g);
                end
            end
        end
        // Logic ops writing back into a direct byte
        if (row == `ROW_OR || row == `ROW_AND || row == `ROW_XOR) begin
            if (col == `COL_DIR_A) begin
                // Accumulator into a direct byte: read, combine, write back
                d = mk(2'd2, 4'd2, grp_logic);
            end else if (col == `COL_DIR_IMM) begin
                // Immediate into a direct byte needs three program bytes
                d = mk(2'd3, 4'd3, grp_logic);
            end
        end
        // Add, add with carry and subtract touch all three flags
        if ((row == `ROW_ADD || row == `ROW_ADD_CY || row == `ROW_SUB_BW)
            && col >= `COL_IMM) begin
            d.flags = '{cy: 1'b1, ac: 1'b1, ov: 1'b1};
        end
        // Conditional branches: cycles hold the taken figure
        if (row == `ROW_CJNE && col >= `COL_IMM) begin
            // Compare-and-jump: the pointer form costs one clock more
            d = mk(2'd3, (col == `COL_IND_LO || col == `COL_IND_HI) ?
                   4'd5 : 4'd4, grp_branch);
            d.cond = 1'b1;
            d.flags.cy = 1'b1;
        end
        if (row == `ROW_DJNZ && col >= `COL_BANK) begin
            // Decrement-and-jump on a bank register
            d = mk(2'd2, 4'd3, grp_branch);
            d.cond = 1'b1;
        end
        // Opcodes that stand alone
        case (op)
            `OPC_CLR_A, `OPC_CPL_A, `OPC_RL_A, `OPC_RR_A,
            `OPC_SWAP_A: d = mk(2'd1, 4'd1, grp_acc);
            `OPC_LROT_CY_A, `OPC_RROT_CY_A, `OPC_DFIX_A: begin
                d = mk(2'd1, 4'd1, grp_acc);
                d.flags.cy = 1'b1;
            end
            `OPC_INC_PTR: d = mk(2'd1, 4'd1, grp_arith);
            // Long arithmetic: multiply four clocks, divide eight
            `OPC_PROD, `OPC_DIV: begin
                d = mk(2'd1, (op == `OPC_PROD) ? `CYC_PROD : `CYC_DIV,
                       grp_muldiv);
                d.flags.cy = 1'b1;
                d.flags.ov = 1'b1;
            end
            // Far moves reach flash or data memory, never off chip
            `OPC_FAR_RD_PTR, `OPC_FAR_RD_R0, `OPC_FAR_RD_R1,
            `OPC_FAR_WR_PTR, `OPC_FAR_WR_R0, `OPC_FAR_WR_R1:
                d = mk(2'd1, `CYC_FAR, grp_far);
            // Carry and accumulator tests: two bytes
            `OPC_JC, `OPC_JNC, `OPC_JZ, `OPC_JNZ: begin
                d = mk(2'd2, 4'd3, grp_branch);
                d.cond = 1'b1;
            end
            // Bit tests and direct decrement: three bytes
            `OPC_JB, `OPC_JNB, `OPC_JBC, `OPC_DJNZ_DIR: begin
                d = mk(2'd3, 4'd4, grp_branch);
                d.cond = 1'b1;
            end
            default: d = d;
        endcase
        return d;
    endfunction

    // True for far moves that write memory
    function automatic logic far_write(input logic [7:0] op);
        return op == `OPC_FAR_WR_PTR || op == `OPC_FAR_WR_R0 ||
               op == `OPC_FAR_WR_R1;
    endfunction

    seq_state_t state_ff; // Idle or executing a multi-cycle instruction
    seq_state_t nxt_state;
    logic [3:0] cnt_ff; // Reaches 1 at the edge that may take the next op
    logic [3:0] nxt_cnt;
    logic rd_pend_ff; // A far read was issued last cycle
    op_info_t info; // Decode of the presented opcode
    logic accept; // Opcode taken this edge
    logic [3:0] run_cycles; // Cycles this instance will really take

    // The next opcode is taken at the edge that closes the last clock of
    // the previous one, so an N-clock instruction spans exactly N edges
    // between takes and the pipeline carries no bubbles; an opcode held
    // during the earlier clocks is simply not taken yet
    assign accept = op_valid && (state_ff == st_idle || cnt_ff == 4'd1);

    // Untaken branches drop one cycle from the taken figure
    always_comb begin
        info = decode(op_code);
        // Taken branches and all other forms keep the full figure
        run_cycles = info.cycles;
        if (info.cond && !branch_taken) begin
            run_cycles = info.cycles - 4'd1;
        end
    end

    // Next state and remaining-cycle count
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        if (accept) begin
            // Counter holds clocks directly; there is no machine cycle.
            // Loading the full count makes the take edge the first clock
            nxt_cnt = run_cycles;
            // Single-clock forms never leave idle
            nxt_state = (run_cycles > 4'd1) ? st_exec : st_idle;
        end else if (state_ff == st_exec) begin
            // One clock consumed per edge
            nxt_cnt = cnt_ff - 4'd1;
            if (cnt_ff == 4'd1) begin
                nxt_state = st_idle;
            end
        end
    end

    // Sequencer registers; busy and last tell the fetch side when to offer
    // the next opcode
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_ff <= st_idle;
            cnt_ff <= 4'd0;
            busy_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            busy_ff <= (nxt_state == st_exec);
            last_ff <= (nxt_state == st_exec) && (nxt_cnt == 4'd1);
        end
    end

    // Completion pulse lands on the instruction's final clock edge
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            done_ff <= 1'b0;
        end else begin
            // Single-clock forms finish at their own take edge; longer
            // ones one edge before the next take may happen, so a take
            // never hides a completion
            done_ff <= (accept && run_cycles == 4'd1) ||
                       (state_ff == st_exec && cnt_ff == 4'd2);
        end
    end

    // Decode record held for the instruction in flight
    // Fields stand until the next take, so they describe that instruction
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            bytes_ff <= 2'd0;
            cycles_ff <= 4'd0;
            group_ff <= grp_other;
            flags_ff <= '0;
        end else if (accept) begin
            bytes_ff <= info.bytes;
            cycles_ff <= run_cycles;
            group_ff <= info.grp;
            flags_ff <= info.flags;
        end
    end

    // Far move request: only on-chip flash or data memory is reached,
    // so no address ever leaves the chip
    // Request pulses last one clock; write flag and address stand
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            flash_req_ff <= 1'b0;
            xram_req_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            mem_addr_ff <= '0;
            mem_wdata_ff <= 8'h00;
        end else begin
            flash_req_ff <= 1'b0;
            xram_req_ff <= 1'b0;
            if (accept && info.grp == grp_far) begin
                mem_we_ff <= far_write(op_code);
                mem_wdata_ff <= far_wdata;
                if (far_flash_sel) begin
                    // Flash keeps the whole address
                    flash_req_ff <= 1'b1;
                    mem_addr_ff <= far_addr;
                end else begin
                    // Data memory wraps within its size
                    xram_req_ff <= 1'b1;
                    mem_addr_ff <= ADDR_W'(far_addr[`XRAM_AW-1:0]);
                end
            end
        end
    end

    // Read data comes back one cycle after the request
    // It is captured once and then held until the next read
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rd_pend_ff <= 1'b0;
            rd_valid_ff <= 1'b0;
            rd_data_ff <= 8'h00;
        end else begin
            rd_pend_ff <= (flash_req_ff || xram_req_ff) && !mem_we_ff;
            rd_valid_ff <= rd_pend_ff;
            if (rd_pend_ff) begin
                rd_data_ff <= far_rdata;
            end
        end
    end

endmodule

// ===== rtl/byte_cpu_timing_map.svh
// Named opcodes, cycle counts and memory sizes for the timing decoder.
// Assumes inclusion by bare name from the package; the decoder sees it through that.
`ifndef BYTE_CPU_TIMING_MAP_SVH
`define BYTE_CPU_TIMING_MAP_SVH
// Opcodes that stand alone in the map
`define OPC_NOP 8'h00
`define OPC_RR_A 8'h03
`define OPC_RROT_CY_A 8'h13
`define OPC_RL_A 8'h23
`define OPC_LROT_CY_A 8'h33
`define OPC_JBC 8'h10
`define OPC_JB 8'h20
`define OPC_JNB 8'h30
`define OPC_JC 8'h40
`define OPC_JNC 8'h50
`define OPC_JZ 8'h60
`define OPC_JNZ 8'h70
`define OPC_DIV 8'h84
`define OPC_INC_PTR 8'hA3
`define OPC_PROD 8'hA4
`define OPC_SWAP_A 8'hC4
`define OPC_DFIX_A 8'hD4
`define OPC_DJNZ_DIR 8'hD5
`define OPC_CLR_A 8'hE4
`define OPC_CPL_A 8'hF4
`define OPC_FAR_RD_PTR 8'hE0
`define OPC_FAR_RD_R0 8'hE2
`define OPC_FAR_RD_R1 8'hE3
`define OPC_FAR_WR_PTR 8'hF0
`define OPC_FAR_WR_R0 8'hF2
`define OPC_FAR_WR_R1 8'hF3
// Opcode rows (upper nibble)
`define ROW_INC 4'h0
`define ROW_DEC 4'h1
`define ROW_ADD 4'h2
`define ROW_ADD_CY 4'h3
`define ROW_OR 4'h4
`define ROW_AND 4'h5
`define ROW_XOR 4'h6
`define ROW_SUB_BW 4'h9
`define ROW_CJNE 4'hB
`define ROW_DJNZ 4'hD
`define ROW_COPY_A 4'hE
// Column groups (lower nibble)
`define COL_DIR_A 4'h2
`define COL_DIR_IMM 4'h3
`define COL_IMM 4'h4
`define COL_DIR 4'h5
`define COL_IND_LO 4'h6
`define COL_IND_HI 4'h7
`define COL_BANK 4'h8
// Cycle counts per instruction form
`define CYC_PROD 4'h4
`define CYC_DIV 4'h8
`define CYC_FAR 4'h3
// On-chip data memory size in bytes and its address width
`define XRAM_BYTES 1024
`define XRAM_AW 10
`endif

// ===== rtl/byte_cpu_timing_pkg.sv
// Types shared by the instruction timing decoder and its bench.
// Assumes the map header is on the include path.
`include "byte_cpu_timing_map.svh"
package byte_cpu_timing_pkg;
    // Broad instruction groups reported with each decode
    typedef enum logic [2:0] {
        grp_other, grp_arith, grp_logic, grp_acc,
        grp_copy, grp_far, grp_branch, grp_muldiv
    } op_group_t;
    // Status word flags an instruction may change: carry, aux, overflow
    typedef struct packed {
        logic cy;
        logic ac;
        logic ov;
    } flag_mask_t;
    // Result of decoding one opcode
    typedef struct packed {
        logic [1:0] bytes;
        logic [3:0] cycles;
        logic cond;
        op_group_t grp;
        flag_mask_t flags;
    } op_info_t;
    // Sequencer states
    typedef enum logic {st_idle, st_exec} seq_state_t;
endpackage

// ===== tb/byte_cpu_timing_chk.sv
// Port checker for the instruction timing decoder, bound to its top.
// Assumes the package and the opcode map are compiled before it.
`timescale 1ns/10ps
module byte_cpu_timing_chk
    import byte_cpu_timing_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic op_valid,
    input wire logic [7:0] op_code,
    input wire logic branch_taken,
    input wire logic far_flash_sel,
    input wire logic [7:0] far_rdata,
    input wire logic [7:0] far_wdata,
    input wire logic busy_ff,
    input wire logic last_ff,
    input wire logic done_ff,
    input wire logic [1:0] bytes_ff,
    input wire logic [3:0] cycles_ff,
    input wire logic [2:0] group_ff,
    input wire logic [2:0] flags_ff,
    input wire logic flash_req_ff,
    input wire logic xram_req_ff,
    input wire logic mem_we_ff,
    input wire logic [ADDR_W-1:0] mem_addr_ff,
    input wire logic [7:0] mem_wdata_ff,
    input wire logic rd_valid_ff,
    input wire logic [7:0] rd_data_ff
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic take; // Opcode accepted at this edge
    logic [3:0] row; // Upper nibble picks the operation
    logic [3:0] col; // Lower nibble picks the addressing form
    assign take = op_valid && (!busy_ff || last_ff);
    assign row = op_code[7:4];
    assign col = op_code[3:0];
    property p_prod;
        take && op_code == `OPC_PROD |=> cycles_ff == 4'h4 ##3 done_ff;
    endproperty
    a_prod: assert property (p_prod) else $error("product timing");
    property p_mflag;
        take && op_code inside {`OPC_PROD, `OPC_DIV}
            |=> group_ff == grp_muldiv && flags_ff == 3'h5;
    endproperty
    a_mflag: assert property (p_mflag) else $error("long flags");
    property p_aflag;
        take && row inside {4'h2, 4'h3, 4'h9} && col >= 4'h4
            |=> group_ff == grp_arith && flags_ff == 3'h7;
    endproperty
    a_aflag: assert property (p_aflag) else $error("add flags");
    property p_wdat;
        take && op_code inside {8'hF0, 8'hF2, 8'hF3}
            |=> mem_wdata_ff == $past(far_wdata);
    endproperty
    a_wdat: assert property (p_wdat) else $error("write data");
    property p_div;
        take && op_code == `OPC_DIV |=> cycles_ff == 4'h8 ##7 done_ff;
    endproperty
    a_div: assert property (p_div) else $error("divide timing");
    property p_bank;
        take && op_code[3] && row inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
            4'h9, 4'hE} |=> bytes_ff == 2'h1 && cycles_ff == 4'h1 && done_ff;
    endproperty
    a_bank: assert property (p_bank) else $error("bank form");
    property p_ind;
        take && op_code[3:1] == 3'h3 && row inside {4'h0, 4'h1, 4'h2, 4'h3,
            4'h4, 4'h5, 4'h6, 4'h9, 4'hE}
            |=> bytes_ff == 2'h1 && cycles_ff == 4'h2 ##1 done_ff;
    endproperty
    a_ind: assert property (p_ind) else $error("indirect form");
    property p_two;
        take && ((col inside {4'h4, 4'h5} && row inside {4'h2, 4'h3, 4'h9})
            || (col == 4'h2 && row inside {4'h4, 4'h5, 4'h6}))
            |=> bytes_ff == 2'h2 && cycles_ff == 4'h2 ##1 done_ff;
    endproperty
    a_two: assert property (p_two) else $error("two byte form");
    property p_rmw;
        take && col == 4'h3 && row inside {4'h4, 4'h5, 4'h6}
            |=> bytes_ff == 2'h3 && cycles_ff == 4'h3 ##2 done_ff;
    endproperty
    a_rmw: assert property (p_rmw) else $error("direct immediate");
    property p_cond;
        take && op_code inside {`OPC_JC, `OPC_JNC, `OPC_JZ, `OPC_JNZ}
            |=> cycles_ff == ($past(branch_taken) ? 4'h3 : 4'h2);
    endproperty
    a_cond: assert property (p_cond) else $error("branch timing");
    property p_far;
        take && op_code inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3}
            |=> (flash_req_ff != xram_req_ff)
            && flash_req_ff == $past(far_flash_sel)
            && mem_we_ff == ($past(op_code) > 8'hE3);
    endproperty
    a_far: assert property (p_far) else $error("far request");
    property p_wrap;
        xram_req_ff |-> mem_addr_ff[ADDR_W-1:10] == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("data address");
    property p_read;
        (flash_req_ff || xram_req_ff) && !mem_we_ff
            |-> ##2 rd_valid_ff && rd_data_ff == $past(far_rdata);
    endproperty
    a_read: assert property (p_read) else $error("far read");
endmodule
bind byte_cpu_timing byte_cpu_timing_chk #(.ADDR_W(ADDR_W)) chk_u (
    .clock(clock), .reset_n(reset_n), .op_valid(op_valid),
    .op_code(op_code), .branch_taken(branch_taken),
    .far_flash_sel(far_flash_sel), .far_rdata(far_rdata),
    .far_wdata(far_wdata), .group_ff(group_ff), .flags_ff(flags_ff),
    .mem_wdata_ff(mem_wdata_ff),
    .busy_ff(busy_ff), .last_ff(last_ff), .done_ff(done_ff),
    .bytes_ff(bytes_ff), .cycles_ff(cycles_ff),
    .flash_req_ff(flash_req_ff), .xram_req_ff(xram_req_ff),
    .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff),
    .rd_valid_ff(rd_valid_ff), .rd_data_ff(rd_data_ff));

// ===== tb/byte_cpu_timing_tb_top.sv
// Self-checking bench for the instruction timing decoder.
// Assumes the package, checker and memory model are compiled first.
`timescale 1ns/10ps
module byte_cpu_timing_tb_top
    import byte_cpu_timing_pkg::*;
;
    logic clock, reset_n, op_valid, branch_taken, far_flash_sel;
    logic busy_ff, last_ff, done_ff, flash_req_ff, xram_req_ff;
    logic mem_we_ff, rd_valid_ff, dchk = 1'b0;
    logic [7:0] op_code, far_wdata, far_rdata, rd_data_ff, d1, d2;
    logic [7:0] mem_wdata_ff; // Write data as the decoder latched it
    logic [15:0] far_addr, mem_addr_ff, a1, a2;
    logic [1:0] bytes_ff;
    logic [3:0] cycles_ff;
    logic [5:0] lp, dn, eq[$], pe[$]; // Notes of {bytes, cycles}
    logic [7:0] rq[$]; // Notes of read data
    logic [31:0] seed = 32'h0000_2f12, r;
    int pt[$], failures = 0, cmp_count = 0, cyc = 0;
    // Opcode as a nibble pair, then byte count and cycle count one nibble each
    logic [15:0] tbl [42] = '{16'h2811, 16'h3a11, 16'h9f11,
        16'h2522, 16'h3522, 16'h9522, 16'h2422, 16'h3422, 16'h9422,
        16'h2612, 16'h3712, 16'h9612, 16'h4712, 16'h5612, 16'h6712,
        16'he612, 16'h0612, 16'h1712, 16'h4811, 16'h5c11, 16'h6f11,
        16'h4222, 16'h5222, 16'h6222, 16'h4333, 16'h5333, 16'h6333,
        16'he411, 16'hf411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
        16'hc411, 16'hd411, 16'he522, 16'he811, 16'ha414, 16'h8418, // 16
        16'ha311, 16'h0411, 16'h1522};
    byte_cpu_timing dut_u (.clock(clock), .reset_n(reset_n),
        .op_valid(op_valid), .op_code(op_code),
        .branch_taken(branch_taken), .far_flash_sel(far_flash_sel),
        .far_addr(far_addr), .far_wdata(far_wdata), .far_rdata(far_rdata),
        .busy_ff(busy_ff), .last_ff(last_ff), .done_ff(done_ff),
        .bytes_ff(bytes_ff), .cycles_ff(cycles_ff), .group_ff(),
        .flags_ff(), .flash_req_ff(flash_req_ff), .xram_req_ff(xram_req_ff),
        .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff),
        .mem_wdata_ff(mem_wdata_ff), .rd_valid_ff(rd_valid_ff),
        .rd_data_ff(rd_data_ff));
    far_mem_model mem_u (.clock(clock), .flash_req(flash_req_ff),
        .xram_req(xram_req_ff), .we(mem_we_ff), .addr(mem_addr_ff),
        .wdata(mem_wdata_ff), .rdata(far_rdata));
    // Xorshift source, fixed start so every run repeats
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, s);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Present one opcode and hold it until the decoder can take it
    task automatic run_op(input logic [7:0] o, input logic bt, fs,
                          input logic [15:0] a, input logic [7:0] d,
                          input logic [5:0] e);
        @(negedge clock);
        op_valid = 1'b1;
        op_code = o;
        branch_taken = bt;
        far_flash_sel = fs;
        far_addr = a;
        far_wdata = d;
        eq.push_back(e);
        while (busy_ff && !last_ff)
            @(negedge clock);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Watcher sees pre-edge values: the same ones the decoder samples
    always @(posedge clock) begin
        cyc++;
        if (done_ff) begin
            dn = pe.pop_front();
            chk("done_time", {4'h0, dn[3:0]}, 8'(cyc - pt.pop_front()));
        end
        if (dchk) begin
            chk("bytes", {6'h0, lp[5:4]}, {6'h0, bytes_ff});
            chk("cycles", {4'h0, lp[3:0]}, {4'h0, cycles_ff});
        end
        dchk = 1'b0;
        if (reset_n && op_valid && (!busy_ff || last_ff)) begin
            lp = eq.pop_front();
            pe.push_back(lp);
            pt.push_back(cyc);
            dchk = 1'b1;
        end
        if (rd_valid_ff)
            chk("rd_data", rq.pop_front(), rd_data_ff);
    end
    initial begin
        #(3000 * 100);
        failures++;
        close_out();
    end
    initial begin
        {reset_n, op_valid, branch_taken, far_flash_sel} = 4'h0;
        {op_code, far_wdata, far_addr} = 32'h0000_0000;
        repeat (4) @(negedge clock);
        reset_n = 1'b1;
        foreach (tbl[i]) begin
            r = rnd();
            run_op(tbl[i][15:8], r[0], r[1], r[31:16], r[15:8],
                   tbl[i][5:0]);
        end
        $display("table of forms done");
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            run_op({2'h1, r[5:4], 4'h0}, r[0], r[1], r[31:16], r[15:8],
                   {2'h2, r[0] ? 4'h3 : 4'h2});
        end
        $display("conditional branches done");
        for (int k = 0; k < 2; k++) begin
            r = rnd();
            {a1, d1, d2} = {r[15:0], r[23:16], r[31:24]};
            a2 = 16'(rnd());
            run_op(8'hf0, 1'b0, 1'b0, a1, d1, 6'h13);
            run_op(8'hf2, 1'b0, 1'b1, a2, d2, 6'h13);
            rq.push_back(d1);
            run_op(8'he0, 1'b0, 1'b0, a1 ^ 16'hfc00, d2, 6'h13);
            rq.push_back(d2);
            run_op(8'he3, 1'b0, 1'b1, a2, d1, 6'h13);
        end
        @(negedge clock);
        op_valid = 1'b0;
        repeat (12) @(negedge clock);
        chk("pending", 8'h00, 8'(pe.size() + rq.size() + eq.size()));
        $display("far moves done");
        close_out();
    end
endmodule

// ===== tb/far_mem_model.sv
// Flash and data memory standing on the far-move port of the decoder.
// Assumes one-cycle request pulses; a read answers on the next cycle.
`timescale 1ns/10ps
module far_mem_model #(
    parameter int ADDR_W = 16
) (
    input wire logic clock,
    input wire logic flash_req,
    input wire logic xram_req,
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] flash_mem [0:(1<<ADDR_W)-1]; // Program space, byte wide
    logic [7:0] xram_mem [0:1023]; // Data memory, wraps at its size
    initial rdata = 8'h5a; // Known start so the toggling is visible
    // Store writes, answer reads a cycle later, else keep the bus moving
    always @(posedge clock) begin
        if (xram_req && we)
            xram_mem[addr[9:0]] <= wdata;
        if (flash_req && we)
            flash_mem[addr] <= wdata;
        if ((flash_req || xram_req) && !we)
            rdata <= flash_req ? flash_mem[addr] : xram_mem[addr[9:0]];
        else
            rdata <= ~rdata; // Released bus never holds the last byte
    end
endmodule
